// [ses_pkg.sv]
// Constants shared by the sensor error and status routing block.
package ses_pkg;
    // Geometry.
    localparam int NUM_CH = 4;
    localparam int NUM_ERR = 6;
    // Register addresses on the serial register port.
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_ROUTE = 8'h19;
    // Status word fields.
    localparam int ST_CHAN_LO = 14;
    localparam int ST_ERR_LO = 8;
    localparam int ST_RESULTS_READY_FLAG = 6;
    localparam int ST_UNREAD_HI = 3;
    // Error vector order: under, over, watchdog, amp high, amp low, zero count.
    localparam int E_UR = 5;
    localparam int E_OR = 4;
    localparam int E_WD = 3;
    localparam int E_AH = 2;
    localparam int E_AL = 1;
    localparam int E_ZC = 0;
    // Routing word fields.
    localparam int CF_OUT_LO = 11;
    localparam int CF_INT_LO = 2;
    localparam int CF_RDY_INT = 0;
    localparam logic [15:0] ROUTE_RESET = 16'h0000;
    // Per-channel result mark positions: under, over, watchdog, amplitude.
    localparam int MK_UR = 3;
    localparam int MK_OR = 2;
    localparam int MK_WD = 1;
    localparam int MK_AE = 0;
    // Five result routing bits follow the error order from under to amp low.
    localparam int RT_UR = 4;
    localparam int RT_OR = 3;
    localparam int RT_WD = 2;
    localparam int RT_AH = 1;
    localparam int RT_AL = 0;
endpackage

// [ses_chan_if.sv]
// Per-channel link between the status controller and one channel tracker.
`timescale 1ns/1ps
interface ses_chan_if;
    logic conv_done;
    logic [4:0] err;
    logic [4:0] route;
    logic upper_rd;
    logic lower_rd;
    logic unread;
    logic [3:0] mark;
    modport ctrl (output conv_done, err, route, upper_rd, lower_rd, input unread, mark);
    modport chan (input conv_done, err, route, upper_rd, lower_rd, output unread, mark);
endinterface

// [ses_chan.sv]
// One channel: unread-result tracking and error marks for its upper word.
`timescale 1ns/1ps
module ses_chan
    import ses_pkg::*;
(
    // Clock and control.
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // Controller side.
    ses_chan_if.chan link
);
    typedef struct packed {
        logic unread;
        logic up_seen;
        logic lo_seen;
        logic [3:0] mark;
    } ses_chan_t;

    ses_chan_t q;
    ses_chan_t next_q;

    ////////////////////////////////////////////////////////////////////////
    // Next state: a completed conversion wins over a finishing read.
    always_comb begin
        next_q = q;
        next_q.up_seen = q.up_seen | link.upper_rd;
        next_q.lo_seen = q.lo_seen | link.lower_rd;
        if (next_q.up_seen && next_q.lo_seen) begin
            next_q.unread = 1'b0;
            next_q.up_seen = 1'b0;
            next_q.lo_seen = 1'b0;
        end
        if (link.conv_done) begin
            next_q.unread = 1'b1;
            next_q.up_seen = 1'b0;
            next_q.lo_seen = 1'b0;
        end
        // Marks belong to the upper word, so an upper-word read retires them; a lower-word read keeps them.
        if (link.upper_rd) begin
            next_q.mark = 4'h0;
        end
        next_q.mark[MK_UR] = next_q.mark[MK_UR] | (link.err[RT_UR] & link.route[RT_UR]);
        next_q.mark[MK_OR] = next_q.mark[MK_OR] | (link.err[RT_OR] & link.route[RT_OR]);
        next_q.mark[MK_WD] = next_q.mark[MK_WD] | (link.err[RT_WD] & link.route[RT_WD]);
        next_q.mark[MK_AE] = next_q.mark[MK_AE] | (link.err[RT_AH] & link.route[RT_AH])
            | (link.err[RT_AL] & link.route[RT_AL]);
    end

    // State register with clock enable.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            q <= '0;
        end else if (ce_in) begin
            q <= next_q;
        end
    end

    assign link.unread = q.unread;
    assign link.mark = q.mark;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    chk_unread_on_done: assert property (@(posedge core_clk_in) disable iff (reset_in)
        ce_in && link.conv_done |=> link.unread)
        else $error("unread flag not set by conversion");
    chk_ur_mark_route: assert property (@(posedge core_clk_in) disable iff (reset_in)
        $rose(link.mark[MK_UR]) |-> $past(link.err[RT_UR] && link.route[RT_UR]))
        else $error("under-range mark without routed error");
endmodule

// [ses_status.sv]
// Error and data-ready status, routing register and interrupt pin.
`timescale 1ns/1ps
module ses_status
    import ses_pkg::*;
(
    // Clock, reset and enable.
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // Serial register port (decoded, same clock).
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Result word read strobes, one bit per channel.
    input wire logic [NUM_CH-1:0] res_upper_rd_in,
    input wire logic [NUM_CH-1:0] res_lower_rd_in,
    // Converter core events.
    input wire logic [1:0] core_chan_in,
    input wire logic conv_done_in,
    input wire logic [NUM_ERR-1:0] err_event_in,
    input wire logic seq_mode_in,
    input wire logic [NUM_CH-1:0] active_mask_in,
    // Result marks, four per channel, and interrupt pin.
    output logic [4*NUM_CH-1:0] result_mark_out,
    output logic interrupt_out_n
);
    typedef struct packed {
        logic [15:0] route;
        logic [NUM_ERR-1:0] err;
        logic [1:0] chan;
        logic results_ready_flag;
        logic [NUM_CH-1:0] seen;
        logic irq_n;
        logic [15:0] rdata;
        logic rvalid;
    } ses_main_t;

    ses_main_t q;
    ses_main_t next_q;
    logic [NUM_CH-1:0] unread;
    logic [15:0] status_word;
    logic [NUM_ERR-1:0] err_set;
    logic [NUM_CH-1:0] chan_hot;
    logic [NUM_CH-1:0] seen_now;
    logic rdy_event;
    logic stat_rd;

    // One-hot decode of a channel index.
    function automatic logic [NUM_CH-1:0] ses_onehot(input logic [1:0] ch);
        logic [NUM_CH-1:0] v;
        v = '0;
        v[ch] = 1'b1;
        return v;
    endfunction

    // Register address match.
    function automatic logic ses_hit(input logic [7:0] a, input logic [7:0] t);
        return a == t;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Channel trackers.
    ses_chan_if chif[NUM_CH]();

    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
            // Only the channel named by the core sees its events.
            assign chif[g].conv_done = conv_done_in & chan_hot[g];
            assign chif[g].err = err_event_in[E_UR:E_AL] & {5{chan_hot[g]}};
            assign chif[g].route = q.route[CF_OUT_LO+4:CF_OUT_LO];
            assign chif[g].upper_rd = res_upper_rd_in[g];
            assign chif[g].lower_rd = res_lower_rd_in[g];
            assign unread[g] = chif[g].unread;
            assign result_mark_out[4*g+3:4*g] = chif[g].mark;
            ses_chan u_chan (
                .core_clk_in(core_clk_in),
                .reset_in(reset_in),
                .ce_in(ce_in),
                .link(chif[g].chan)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Decode and event qualification.
    always_comb begin
        chan_hot = ses_onehot(core_chan_in);
        stat_rd = reg_rd_in & ses_hit(reg_addr_in, ADDR_STATUS);
        // An error is recorded only when routed to the pin and status.
        err_set = err_event_in & q.route[CF_INT_LO+NUM_ERR-1:CF_INT_LO];
        // Sequential mode waits until every active channel has reported.
        seen_now = q.seen | (conv_done_in ? chan_hot : '0);
        if (seq_mode_in) begin
            rdy_event = conv_done_in && (active_mask_in != '0)
                && ((seen_now & active_mask_in) == active_mask_in);
        end else begin
            rdy_event = conv_done_in;
        end
    end

    // Status word as the host sees it; unused bits stay zero.
    always_comb begin
        status_word = 16'h0000;
        status_word[ST_CHAN_LO+1:ST_CHAN_LO] = q.chan;
        status_word[ST_ERR_LO+NUM_ERR-1:ST_ERR_LO] = q.err;
        status_word[ST_RESULTS_READY_FLAG] = q.results_ready_flag;
        for (int i = 0; i < NUM_CH; i++) begin
            status_word[ST_UNREAD_HI-i] = unread[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state. Every hardware set wins over a read that clears.
    always_comb begin
        next_q = q;
        next_q.rvalid = reg_rd_in;
        if (reg_rd_in) begin
            if (ses_hit(reg_addr_in, ADDR_STATUS)) begin
                next_q.rdata = status_word;
            end else if (ses_hit(reg_addr_in, ADDR_ROUTE)) begin
                next_q.rdata = q.route;
            end else begin
                next_q.rdata = 16'h0000;
            end
        end
        // Reserved routing bits are stored as written.
        if (reg_wr_in && ses_hit(reg_addr_in, ADDR_ROUTE)) begin
            next_q.route = reg_wdata_in;
        end
        // Reading status retires errors, ready and the channel field.
        if (stat_rd) begin
            next_q.err = '0;
            next_q.results_ready_flag = 1'b0;
            next_q.chan = 2'h0;
        end
        // Reading the named channel's upper word also retires the field.
        if (res_upper_rd_in[q.chan]) begin
            next_q.chan = 2'h0;
        end
        next_q.err = next_q.err | err_set;
        if (err_set != '0) begin
            next_q.chan = core_chan_in;
        end
        // Collect channels in sequential mode; restart after each round.
        if (!seq_mode_in) begin
            next_q.seen = '0;
        end else if (rdy_event) begin
            next_q.seen = '0;
        end else begin
            next_q.seen = seen_now;
        end
        if (rdy_event && q.route[CF_RDY_INT]) begin
            next_q.results_ready_flag = 1'b1;
        end
        next_q.irq_n = !((next_q.err != '0) || next_q.results_ready_flag);
    end

    // State register with clock enable.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            q.route <= ROUTE_RESET;
            q.err <= '0;
            q.chan <= 2'h0;
            q.results_ready_flag <= 1'b0;
            q.seen <= '0;
            q.irq_n <= 1'b1;
            q.rdata <= 16'h0000;
            q.rvalid <= 1'b0;
        end else if (ce_in) begin
            q <= next_q;
        end
    end

    // Outputs straight from state.
    assign reg_rdata_out = q.rdata;
    assign reg_rvalid_out = q.rvalid;
    assign interrupt_out_n = q.irq_n;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    // A status read with nothing new arriving.
    sequence s_quiet_read;
        ce_in && stat_rd && (err_set == '0) && !rdy_event;
    endsequence

    // One more quiet enabled cycle after that read.
    sequence s_quiet_after;
        ce_in && (err_set == '0) && !rdy_event;
    endsequence

    chk_wd_flag_set: assert property (
        ce_in && err_event_in[E_WD] && q.route[CF_INT_LO+E_WD]
        |=> status_word[ST_ERR_LO+E_WD])
        else $error("watchdog flag not set");
    chk_ahe_flag_set: assert property (
        ce_in && err_event_in[E_AH] && q.route[CF_INT_LO+E_AH]
        |=> status_word[ST_ERR_LO+E_AH])
        else $error("amplitude high flag not set");
    chk_ale_flag_set: assert property (
        ce_in && err_event_in[E_AL] && q.route[CF_INT_LO+E_AL]
        |=> status_word[ST_ERR_LO+E_AL])
        else $error("amplitude low flag not set");
    chk_zc_flag_set: assert property (
        ce_in && err_event_in[E_ZC] && q.route[CF_INT_LO+E_ZC]
        |=> status_word[ST_ERR_LO+E_ZC])
        else $error("zero count flag not set");
    chk_read_clears_err: assert property (
        s_quiet_read |=> (q.err == '0) && !q.results_ready_flag)
        else $error("status read did not clear flags");
    chk_read_returns_old: assert property (
        ce_in && stat_rd |=> reg_rvalid_out && (reg_rdata_out == $past(status_word)))
        else $error("status read returned wrong word");
    chk_results_ready_flag_single: assert property (
        ce_in && !seq_mode_in && conv_done_in && q.route[CF_RDY_INT] |=> q.results_ready_flag)
        else $error("ready flag missed in single mode");
    chk_rsvd_zero: assert property (
        reg_rvalid_out && $past(ce_in && stat_rd)
        |-> (reg_rdata_out[7] == 1'b0) && (reg_rdata_out[5:4] == 2'h0))
        else $error("reserved status bits not zero");
    chk_ur_needs_route: assert property (
        $rose(q.err[E_UR]) |-> $past(err_event_in[E_UR] && q.route[CF_INT_LO+E_UR]))
        else $error("under-range flag without routing");
    chk_rdy_needs_route: assert property (
        $rose(q.results_ready_flag) |-> $past(q.route[CF_RDY_INT]))
        else $error("ready flag without routing");
    chk_chan_latch: assert property (
        ce_in && (err_set != '0) |=> q.chan == $past(core_chan_in))
        else $error("error channel not latched");
    chk_irq_release: assert property (
        s_quiet_read |=> interrupt_out_n ##1 s_quiet_after |=> interrupt_out_n)
        else $error("interrupt not released after read");
    chk_irq_pending: assert property (
        ce_in && (err_set != '0) |=> !interrupt_out_n)
        else $error("interrupt not asserted on error");
endmodule

// [ses_host_model.sv]
// Host model: register strobes and result-word reads toward the status block.
`timescale 1ns/1ps
module ses_host_model
    import ses_pkg::*;
#(
    parameter int DRIVE_START = 100
)
(
    // Clock.
    input wire logic core_clk_in,
    // Register port.
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic [15:0] reg_wdata_out,
    output logic reg_rd_out,
    input wire logic [15:0] reg_rdata_in,
    input wire logic reg_rvalid_in,
    // Result word read strobes.
    output logic [NUM_CH-1:0] upper_rd_out,
    output logic [NUM_CH-1:0] lower_rd_out
);
    // Drive current setting the host keeps for each channel.
    int sensor_drive_current_setting [NUM_CH];

    // Idle values; address and data are scrambled while no strobe is up.
    initial begin
        for (int i = 0; i < NUM_CH; i++) begin
            sensor_drive_current_setting[i] = DRIVE_START;
        end
        reg_addr_out = 8'hA5;
        reg_wr_out = 1'b0;
        reg_wdata_out = 16'h5A5A;
        reg_rd_out = 1'b0;
        upper_rd_out = 4'h0;
        lower_rd_out = 4'h0;
    end

    // Routing write; reserved bits always go out as zero.
    task automatic write_route(input logic [15:0] value);
        @(negedge core_clk_in);
        reg_addr_out = ADDR_ROUTE;
        reg_wdata_out = value & 16'hF8FD;
        reg_wr_out = 1'b1;
        @(negedge core_clk_in);
        reg_wr_out = 1'b0;
        reg_wdata_out = ~reg_wdata_out;
        reg_addr_out = ~reg_addr_out;
    endtask

    // One read strobe; the answer is taken while the valid pulse stands.
    task automatic read_reg(input logic [7:0] addr, output logic [15:0] data, output logic ok);
        @(negedge core_clk_in);
        reg_addr_out = addr;
        reg_rd_out = 1'b1;
        @(negedge core_clk_in);
        reg_rd_out = 1'b0;
        reg_addr_out = ~addr;
        ok = reg_rvalid_in;
        data = reg_rdata_in;
        // An amplitude-high report makes the host back off that channel's drive.
        if (addr == ADDR_STATUS && ok && data[ST_ERR_LO + E_AH]) begin
            if (sensor_drive_current_setting[data[ST_CHAN_LO +: 2]] > 0) begin
                sensor_drive_current_setting[data[ST_CHAN_LO +: 2]]--;
            end
        end
    endtask

    // One result word read pulse for one channel.
    task automatic read_result(input int ch, input logic upper);
        @(negedge core_clk_in);
        if (upper) begin
            upper_rd_out[ch] = 1'b1;
        end else begin
            lower_rd_out[ch] = 1'b1;
        end
        @(negedge core_clk_in);
        upper_rd_out = 4'h0;
        lower_rd_out = 4'h0;
    endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the sensor error and status routing block.
`timescale 1ns/1ps
module tb_top;
    import ses_pkg::*;
    logic core_clk_in, reset_in, ce_in, reg_wr, reg_rd, reg_rvalid, conv_done_in;
    logic seq_mode_in, interrupt_out_n, rd_ok;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, result_mark_out, rd_data, rt;
    logic [3:0] upper_rd, lower_rd, active_mask_in;
    logic [1:0] core_chan_in;
    logic [5:0] err_event_in;
    int err_count = 0;
    int checks = 0;
    int seed = 32'h22660881;
    int cycles = 0;
    int e, ch;
    int drv;
    int ah_exp [NUM_CH];
    localparam int DRIVE_START = 100;

    // Block under test and the host that reads it.
    ses_status u_ses_status (.core_clk_in(core_clk_in), .reset_in(reset_in), .ce_in(ce_in),
        .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata),
        .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid),
        .res_upper_rd_in(upper_rd), .res_lower_rd_in(lower_rd), .core_chan_in(core_chan_in),
        .conv_done_in(conv_done_in), .err_event_in(err_event_in), .seq_mode_in(seq_mode_in),
        .active_mask_in(active_mask_in), .result_mark_out(result_mark_out),
        .interrupt_out_n(interrupt_out_n));
    ses_host_model #(.DRIVE_START(DRIVE_START)) u_ses_host_model (.core_clk_in(core_clk_in),
        .reg_addr_out(reg_addr),
        .reg_wr_out(reg_wr), .reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd),
        .reg_rdata_in(reg_rdata), .reg_rvalid_in(reg_rvalid), .upper_rd_out(upper_rd),
        .lower_rd_out(lower_rd));

    // Free-running clock, 100 ns period.
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end

    // Compare one value and count it.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Closing report and end of run.
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Cuts a hang short.
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    // Status read with its valid pulse checked.
    task automatic read_status(input logic [15:0] exp, input string what);
        u_ses_host_model.read_reg(ADDR_STATUS, rd_data, rd_ok);
        check("read valid", 16'(rd_ok), 16'h0001);
        check(what, rd_data, exp);
    endtask

    // One core event set for one channel, then idle with a random channel.
    task automatic fire(input int c, input logic [5:0] ev, input logic done);
        @(negedge core_clk_in);
        core_chan_in = 2'(c);
        err_event_in = ev;
        conv_done_in = done;
        @(negedge core_clk_in);
        err_event_in = 6'h00;
        conv_done_in = 1'b0;
        core_chan_in = 2'($random(seed));
    endtask

    // Expected status after error e on channel c under routing r.
    function automatic logic [15:0] exp_status(int c, int err, logic [15:0] r);
        exp_status = 16'h0000;
        if (r[CF_INT_LO + err]) begin
            exp_status = (16'(c) << ST_CHAN_LO) | (16'h0001 << (ST_ERR_LO + err));
        end
    endfunction

    // Expected result marks; zero count has no mark, both amplitude errors share one.
    function automatic logic [15:0] exp_mark(int c, int err, logic [15:0] r);
        exp_mark = 16'h0000;
        if (err > 0 && r[CF_OUT_LO - 1 + err]) begin
            exp_mark = 16'h0001 << (4 * c + (err > 1 ? err - 2 : 0));
        end
    endfunction

    // Main sequence.
    initial begin
        reset_in = 1'b1;
        ce_in = 1'b1;
        core_chan_in = 2'h0;
        conv_done_in = 1'b0;
        err_event_in = 6'h00;
        seq_mode_in = 1'b0;
        active_mask_in = 4'hF;
        repeat (4) @(negedge core_clk_in);
        reset_in = 1'b0;
        read_status(16'h0000, "status after reset");
        u_ses_host_model.read_reg(ADDR_ROUTE, rd_data, rd_ok);
        check("route after reset", rd_data, ROUTE_RESET);
        u_ses_host_model.read_reg(8'h3C, rd_data, rd_ok);
        check("unmapped read", rd_data, 16'h0000);
        check("pin after reset", 16'(interrupt_out_n), 16'h0001);
        $display("test reset done");
        // Clock enable low: a routing write and a full event set are ignored.
        @(negedge core_clk_in);
        ce_in = 1'b0;
        u_ses_host_model.write_route(16'hFFFF);
        fire(2, 6'h3F, 1'b1);
        check("frozen pin", 16'(interrupt_out_n), 16'h0001);
        check("frozen marks", result_mark_out, 16'h0000);
        @(negedge core_clk_in);
        ce_in = 1'b1;
        u_ses_host_model.read_reg(ADDR_ROUTE, rd_data, rd_ok);
        check("frozen route", rd_data, ROUTE_RESET);
        read_status(16'h0000, "frozen status");
        $display("test freeze done");
        // Every error on every channel fully routed, then random routing.
        for (int i = 0; i < 64; i++) begin
            rt = (i < 24) ? 16'hFFFF : 16'($random(seed));
            e = (i < 24) ? i % 6 : {$random(seed)} % 6;
            ch = (i < 24) ? i / 6 : {$random(seed)} % 4;
            u_ses_host_model.write_route(rt);
            rt = rt & 16'hF8FD;
            u_ses_host_model.read_reg(ADDR_ROUTE, rd_data, rd_ok);
            check("route readback", rd_data, rt);
            if (e == E_AH && rt[CF_INT_LO + E_AH]) begin
                ah_exp[ch]++;
            end
            fire(ch, 6'h01 << e, 1'b0);
            check("error pin", 16'(interrupt_out_n), 16'(!rt[CF_INT_LO + e]));
            check("result mark", result_mark_out, exp_mark(ch, e, rt));
            read_status(exp_status(ch, e, rt), "error status");
            read_status(16'h0000, "status cleared");
            check("pin released", 16'(interrupt_out_n), 16'h0001);
            u_ses_host_model.read_result(ch, 1'b1);
            check("mark cleared", result_mark_out, 16'h0000);
        end
        $display("test errors done");
        // Every reported amplitude-high error lowered that channel's drive once.
        for (int c = 0; c < NUM_CH; c++) begin
            drv = u_ses_host_model.sensor_drive_current_setting[c];
            check("drive lowered", 16'(drv), 16'(DRIVE_START - ah_exp[c]));
        end
        // Error channel field: kept over another channel's read, retired by its own.
        u_ses_host_model.write_route(16'hFFFF);
        fire(3, 6'h01 << E_WD, 1'b0);
        u_ses_host_model.read_result(2, 1'b1);
        read_status(16'hC800, "channel kept");
        fire(3, 6'h01 << E_WD, 1'b0);
        u_ses_host_model.read_result(3, 1'b1);
        check("own read marks", result_mark_out, 16'h0000);
        read_status(16'h0800, "channel retired");
        $display("test channel field done");
        // Single-channel ready and unread tracking on every channel.
        u_ses_host_model.write_route(16'h0001);
        for (int c = 0; c < 4; c++) begin
            fire(c, 6'h00, 1'b1);
            check("ready pin", 16'(interrupt_out_n), 16'h0000);
            read_status(16'h0040 | (16'h0001 << (3 - c)), "ready status");
            read_status(16'h0001 << (3 - c), "unread held");
            u_ses_host_model.read_result(c, 1'b1);
            read_status(16'h0001 << (3 - c), "unread after upper");
            u_ses_host_model.read_result(c, 1'b0);
            read_status(16'h0000, "unread cleared");
        end
        u_ses_host_model.write_route(16'h0000);
        fire(1, 6'h00, 1'b1);
        check("ready off pin", 16'(interrupt_out_n), 16'h0001);
        read_status(16'h0004, "ready off");
        u_ses_host_model.read_result(1, 1'b0);
        u_ses_host_model.read_result(1, 1'b1);
        $display("test single ready done");
        // Sequential mode: ready only once all active channels converted.
        u_ses_host_model.write_route(16'h0001);
        seq_mode_in = 1'b1;
        active_mask_in = 4'h5;
        fire(0, 6'h00, 1'b1);
        read_status(16'h0008, "sequence partial");
        fire(2, 6'h00, 1'b1);
        read_status(16'h004A, "sequence complete");
        $display("test sequential ready done");
        print_verdict();
    end
endmodule
